// ### design/tcoh_pkg.sv
package tcoh_pkg;
  // register byte offsets
  localparam logic [7:0]  TCOH_STATUS_OFS  = 8'h00;
  localparam logic [7:0]  TCOH_TXTI_OFS    = 8'h10;
  localparam logic [7:0]  TCOH_RXTI_OFS    = 8'h20;
  // status register fields
  localparam int          TCOH_ST_LOSS     = 0;
  localparam int          TCOH_ST_RDEF     = 1;
  localparam int          TCOH_ST_ODEF     = 2;
  localparam int          TCOH_ST_AIS      = 3;
  localparam int          TCOH_ST_VIOL     = 4;
  localparam logic [31:0] TCOH_TXTI_RST    = 32'h0000_0000;
  // multiframe positions, frames numbered 1 to 76
  localparam logic [6:0]  TCOH_MF_LEN      = 7'h4c;
  localparam logic [6:0]  TCOH_MF_FAS_END  = 7'h08;
  localparam logic [6:0]  TCOH_MF_TI_FIRST = 7'h09;
  localparam logic [6:0]  TCOH_MF_TI_LAST  = 7'h48;
  localparam logic [6:0]  TCOH_MF_RDEF     = 7'h49;
  localparam logic [6:0]  TCOH_MF_ODEF     = 7'h4a;
  localparam logic [11:0] TCOH_FAS_SEARCH  = 12'hffe;
  localparam logic [1:0]  TCOH_FAS_ONES    = 2'h3;
  localparam logic [1:0]  TCOH_FAS_LAST    = 2'h2;
  // incoming error codes
  localparam logic [3:0]  TCOH_IEC_AIS     = 4'he;
  localparam logic [3:0]  TCOH_IEC_ZERO    = 4'h9;
  localparam logic [3:0]  TCOH_IEC_MAX     = 4'h8;
  localparam logic [1:0]  TCOH_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  TCOH_RESP_SLVERR = 2'h2;

  // one byte of the path frame with its position markers
  typedef struct packed {
    logic       fs;
    logic       em;
    logic       nr;
    logic [7:0] data;
  } tcoh_beat_t;

  typedef enum logic {TCOH_LOST, TCOH_LOCKED} tcoh_align_t;
endpackage

// ### design/tcoh_top.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - source sends remote defect in frame 73
// - bits 7-8 form 76-frame multiframe
// - remote error bit copied into bit 5
// - source sends outgoing defect in frame 74
// - outgoing error bit copied into bit 6
// - alignment pattern in frames 1 to 8
// - transmit trace in frames 9 to 72
// - reserved bits of frames 73-76 zero
// - source counts parity violations of previous frame
// - violation count coded into bits 1-4
// - signal fail sends code 1110
// - parity byte compensated for overhead rewrite
// - sink parity mismatch flags outgoing block error
// - count difference flags tc block error
// - codes above eight decode as zero
// - error code taken unfiltered, ais extracted
// - sink recovers trace from frames 9-72
// - sink extracts far error and remote defect
// - sink extracts outgoing error and defect
// - sink searches alignment pattern, keeps checking
// - two bad patterns lose, one good locks
// - sink zeroes overhead byte, compensates parity
// - loss defect follows alignment state
// - code 1110 signals incoming ais
module tcoh_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire tcoh_pkg::tcoh_beat_t src_in,
  input  wire logic                src_in_valid,
  output      tcoh_pkg::tcoh_beat_t src_out,
  output      logic                src_out_valid,
  input  wire logic                remote_defect_request,
  input  wire logic                remote_error_count_in,
  input  wire logic                outgoing_error_indication,
  input  wire logic                outgoing_defect_request,
  input  wire logic                incoming_signal_fail,
  input  wire tcoh_pkg::tcoh_beat_t snk_in,
  input  wire logic                snk_in_valid,
  output      tcoh_pkg::tcoh_beat_t snk_out,
  output      logic                snk_out_valid,
  output      logic                outgoing_block_error,
  output      logic                tc_block_error,
  output      logic                far_block_error,
  output      logic                outgoing_far_block_error,
  output      logic                remote_defect,
  output      logic                outgoing_defect,
  output      logic                incoming_ais,
  output      logic                tc_loss_defect,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import tcoh_pkg::*;

  function automatic logic [3:0] ones_in(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int b = 0; b < 8; b++) begin
      n = n + {3'h0, v[b]};
    end
    return n;
  endfunction

  function automatic logic [3:0] abs_diff(input logic [3:0] a,
                                          input logic [3:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // lane 0 is the source direction, lane 1 the sink direction
  tcoh_beat_t lane_in   [2];
  logic       lane_vld  [2];
  logic [7:0] lane_nr   [2];
  tcoh_beat_t out_reg   [2];
  logic       ovld_reg  [2];
  logic [3:0] viol_reg  [2];
  logic [3:0] viol_now  [2];

  assign lane_in[0]  = src_in;
  assign lane_in[1]  = snk_in;
  assign lane_vld[0] = src_in_valid;
  assign lane_vld[1] = snk_in_valid;

  for (genvar l = 0; l < 2; l++) begin : g_lane
    logic [7:0] bip_acc_reg;
    logic [7:0] bip_prev_reg;
    logic [7:0] em_in_reg;
    logic [7:0] em_out_reg;
    logic [7:0] nr_in_reg;
    logic [7:0] nr_out_reg;
    logic [7:0] em_new;
    tcoh_beat_t b;
    assign b = lane_in[l];
    // even parity over the whole previous frame against this parity byte
    assign viol_now[l] = ones_in(bip_prev_reg ^ b.data);
    // the overhead byte follows the parity byte, so the stored overhead
    // values still belong to the previous frame here
    assign em_new = em_in_reg ^ em_out_reg ^ nr_in_reg ^ nr_out_reg
                    ^ b.data;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        bip_acc_reg  <= 8'h00;
        bip_prev_reg <= 8'h00;
        em_in_reg    <= 8'h00;
        em_out_reg   <= 8'h00;
        nr_in_reg    <= 8'h00;
        nr_out_reg   <= 8'h00;
        viol_reg[l]  <= 4'h0;
        out_reg[l]   <= '0;
        ovld_reg[l]  <= 1'b0;
      end else begin
        ovld_reg[l] <= lane_vld[l];
        if (lane_vld[l]) begin
          bip_acc_reg <= b.fs ? b.data : bip_acc_reg ^ b.data;
          out_reg[l]  <= '{fs: b.fs, em: b.em, nr: b.nr,
                           data: b.em ? em_new
                                 : b.nr ? lane_nr[l] : b.data};
          if (b.fs) begin
            bip_prev_reg <= bip_acc_reg;
          end
          if (b.em) begin
            viol_reg[l] <= viol_now[l];
            em_in_reg   <= b.data;
            em_out_reg  <= em_new;
          end
          if (b.nr) begin
            nr_in_reg  <= b.data;
            nr_out_reg <= lane_nr[l];
          end
        end
      end
    end
  end

  assign src_out       = out_reg[0];
  assign src_out_valid = ovld_reg[0];
  assign snk_out       = out_reg[1];
  assign snk_out_valid = ovld_reg[1];

  // ---------------- source overhead insertion ----------------
  logic [6:0]   tx_mf_reg;
  logic [127:0] tx_sh_reg;
  logic [31:0]  txti_reg [4];
  logic         rei_pend_reg;
  logic         oei_pend_reg;
  logic [3:0]   tx_iec;
  logic [1:0]   tx_mf_bits;
  logic         tx_nr_beat;
  logic         tx_fs_beat;
  logic         tx_rei;
  logic         tx_oei;

  assign tx_nr_beat = src_in_valid && src_in.nr;
  assign tx_fs_beat = src_in_valid && src_in.fs;
  // a pulse arriving on the overhead beat itself still makes this frame
  assign tx_rei = rei_pend_reg | remote_error_count_in;
  assign tx_oei = oei_pend_reg | outgoing_error_indication;
  assign tx_iec = incoming_signal_fail ? TCOH_IEC_AIS
                : (viol_reg[0] == 4'h0) ? TCOH_IEC_ZERO
                : viol_reg[0];
  assign tx_mf_bits =
      (tx_mf_reg < TCOH_MF_FAS_END)   ? TCOH_FAS_ONES
    : (tx_mf_reg == TCOH_MF_FAS_END)  ? TCOH_FAS_LAST
    : (tx_mf_reg <= TCOH_MF_TI_LAST)  ? tx_sh_reg[127:126]
    : (tx_mf_reg == TCOH_MF_RDEF)     ? {1'b0, remote_defect_request}
    : (tx_mf_reg == TCOH_MF_ODEF)     ? {outgoing_defect_request, 1'b0}
    : 2'h0;
  assign lane_nr[0] = {tx_iec, tx_rei, tx_oei, tx_mf_bits};
  assign lane_nr[1] = 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_mf_reg    <= TCOH_MF_LEN;
      tx_sh_reg    <= '0;
      rei_pend_reg <= 1'b0;
      oei_pend_reg <= 1'b0;
    end else begin
      if (tx_fs_beat) begin
        tx_mf_reg <= (tx_mf_reg == TCOH_MF_LEN) ? 7'h01
                     : tx_mf_reg + 7'h01;
      end
      rei_pend_reg <= tx_nr_beat ? 1'b0 : tx_rei;
      oei_pend_reg <= tx_nr_beat ? 1'b0 : tx_oei;
      if (tx_nr_beat && tx_mf_reg == TCOH_MF_FAS_END) begin
        tx_sh_reg <= {txti_reg[0], txti_reg[1], txti_reg[2], txti_reg[3]};
      end else if (tx_nr_beat && tx_mf_reg >= TCOH_MF_TI_FIRST
                   && tx_mf_reg <= TCOH_MF_TI_LAST) begin
        tx_sh_reg <= {tx_sh_reg[125:0], 2'h0};
      end
    end
  end

  // ---------------- sink extraction and alignment ----------------
  tcoh_align_t  align_reg;
  logic         fas_err_reg;
  logic [6:0]   rx_mf_reg;
  logic [11:0]  fas_sh_reg;
  logic [127:0] rx_sh_reg;
  logic [127:0] accepted_trace_id_reg;
  logic         rx_nr_beat;
  logic [11:0]  fas_sh_next;
  logic         fas_ok;
  logic [3:0]   rx_iec;
  logic [3:0]   rx_iec_count;
  logic         rx_in_ti;

  assign rx_nr_beat   = snk_in_valid && snk_in.nr;
  assign rx_iec       = snk_in.data[7:4];
  assign rx_iec_count = (rx_iec <= TCOH_IEC_MAX) ? rx_iec : 4'h0;
  assign fas_sh_next  = {fas_sh_reg[9:0], snk_in.data[1:0]};
  assign fas_ok       = (fas_sh_next == TCOH_FAS_SEARCH);
  assign rx_in_ti     = rx_mf_reg >= TCOH_MF_TI_FIRST
                        && rx_mf_reg <= TCOH_MF_TI_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      align_reg                <= TCOH_LOST;
      fas_err_reg              <= 1'b0;
      rx_mf_reg                <= TCOH_MF_LEN;
      fas_sh_reg               <= 12'h000;
      rx_sh_reg                <= '0;
      accepted_trace_id_reg                 <= '0;
      outgoing_block_error     <= 1'b0;
      tc_block_error           <= 1'b0;
      far_block_error          <= 1'b0;
      outgoing_far_block_error <= 1'b0;
      remote_defect            <= 1'b0;
      outgoing_defect          <= 1'b0;
      incoming_ais             <= 1'b0;
      tc_loss_defect           <= 1'b1;
    end else begin
      outgoing_block_error     <= snk_in_valid && snk_in.em
                                  && viol_now[1] != 4'h0;
      tc_block_error           <= 1'b0;
      far_block_error          <= 1'b0;
      outgoing_far_block_error <= 1'b0;
      tc_loss_defect           <= (align_reg == TCOH_LOST);
      if (snk_in_valid && snk_in.fs) begin
        rx_mf_reg <= (rx_mf_reg == TCOH_MF_LEN) ? 7'h01
                     : rx_mf_reg + 7'h01;
      end
      if (rx_nr_beat) begin
        fas_sh_reg <= fas_sh_next;
        tc_block_error <= abs_diff(viol_reg[1], rx_iec_count)
                          != 4'h0;
        far_block_error          <= snk_in.data[3];
        outgoing_far_block_error <= snk_in.data[2];
        incoming_ais             <= (rx_iec == TCOH_IEC_AIS);
        unique case (align_reg)
          TCOH_LOST: begin
            if (fas_ok) begin
              align_reg   <= TCOH_LOCKED;
              fas_err_reg <= 1'b0;
              rx_mf_reg   <= TCOH_MF_FAS_END;
            end
          end
          TCOH_LOCKED: begin
            if (rx_mf_reg == TCOH_MF_FAS_END) begin
              // only a second bad pattern in a row drops the lock
              fas_err_reg <= !fas_ok && !fas_err_reg;
              if (!fas_ok && fas_err_reg) begin
                align_reg <= TCOH_LOST;
              end
            end
            if (rx_in_ti) begin
              rx_sh_reg <= {rx_sh_reg[125:0], snk_in.data[1:0]};
            end
            if (rx_mf_reg == TCOH_MF_TI_LAST) begin
              accepted_trace_id_reg <= {rx_sh_reg[125:0], snk_in.data[1:0]};
            end
            if (rx_mf_reg == TCOH_MF_RDEF) begin
              remote_defect <= snk_in.data[0];
            end
            if (rx_mf_reg == TCOH_MF_ODEF) begin
              outgoing_defect <= snk_in.data[1];
            end
          end
        endcase
      end
    end
  end

  // ---------------- AXI4-Lite register slave ----------------
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_fire;
  logic              aw_got_next;
  logic              w_got_next;
  logic              rvalid_next;
  logic              wr_is_ti;
  logic [1:0]        wr_idx;
  logic [31:0]       rd_mux;
  logic              rd_ok;
  logic [1:0]        rd_idx;
  logic [31:0]       status_word;

  assign aw_hs       = s_axi_awvalid && s_axi_awready;
  assign w_hs        = s_axi_wvalid && s_axi_wready;
  assign ar_hs       = s_axi_arvalid && s_axi_arready;
  assign wr_fire     = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign aw_got_next = !wr_fire && (aw_got_reg || aw_hs);
  assign w_got_next  = !wr_fire && (w_got_reg || w_hs);
  assign rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);
  assign wr_is_ti    = awaddr_reg[ADDR_W-1:4] == TCOH_TXTI_OFS[7:4]
                       && awaddr_reg[1:0] == 2'h0;
  assign wr_idx      = awaddr_reg[3:2];
  assign rd_idx      = s_axi_araddr[3:2];
  assign status_word = {24'h0, viol_reg[0], incoming_ais,
                        outgoing_defect, remote_defect, tc_loss_defect};
  assign rd_ok = s_axi_araddr[1:0] == 2'h0
                 && (s_axi_araddr == ADDR_W'(TCOH_STATUS_OFS)
                 || s_axi_araddr[ADDR_W-1:4] == TCOH_TXTI_OFS[7:4]
                 || s_axi_araddr[ADDR_W-1:4] == TCOH_RXTI_OFS[7:4]);
  assign rd_mux =
      !rd_ok ? 32'h0
    : (s_axi_araddr[ADDR_W-1:4] == TCOH_TXTI_OFS[7:4]) ? txti_reg[rd_idx]
    : (s_axi_araddr[ADDR_W-1:4] == TCOH_RXTI_OFS[7:4])
      ? accepted_trace_id_reg[7'(127 - 32 * int'(rd_idx)) -: 32]
    : status_word;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awaddr_reg    <= '0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TCOH_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= TCOH_RESP_OKAY;
      for (int i = 0; i < 4; i++) begin
        txti_reg[i] <= TCOH_TXTI_RST;
      end
    end else begin
      aw_got_reg    <= aw_got_next;
      w_got_reg     <= w_got_next;
      s_axi_awready <= !aw_got_next;
      s_axi_wready  <= !w_got_next;
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_is_ti ? TCOH_RESP_OKAY : TCOH_RESP_SLVERR;
        for (int k = 0; k < 4; k++) begin
          if (wr_is_ti && wstrb_reg[k]) begin
            txti_reg[wr_idx][8*k +: 8] <= wdata_reg[8*k +: 8];
          end
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_hs) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? TCOH_RESP_OKAY : TCOH_RESP_SLVERR;
      end
    end
  end

  // ---------------- assertions ----------------
  a_iec_ais_code: assert property (@(posedge clk) disable iff (!rst_n)
    tx_nr_beat && incoming_signal_fail
    |=> src_out_valid && src_out.nr && src_out.data[7:4] == 4'he)
    else $error("signal fail code not inserted");
  a_iec_zero_code: assert property (@(posedge clk) disable iff (!rst_n)
    tx_nr_beat && !incoming_signal_fail && viol_reg[0] == 4'h0
    |=> src_out.data[7:4] == 4'h9)
    else $error("zero violations not coded as 1001");
  a_fas_ones: assert property (@(posedge clk) disable iff (!rst_n)
    tx_nr_beat && tx_mf_reg >= 7'h01 && tx_mf_reg <= 7'h07
    |=> src_out.data[1:0] == 2'h3)
    else $error("alignment ones missing");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    tx_nr_beat && tx_mf_reg >= 7'h4b |=> src_out.data[1:0] == 2'h0)
    else $error("reserved multiframe bits not zero");
  a_rei_copy: assert property (@(posedge clk) disable iff (!rst_n)
    remote_error_count_in ##1 tx_nr_beat
    |=> src_out.data[3])
    else $error("remote error bit lost");
  a_sink_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rx_nr_beat |=> snk_out_valid && snk_out.nr && snk_out.data == 8'h00)
    else $error("sink overhead byte not cleared");
  a_ais_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx_nr_beat |=> incoming_ais == ($past(snk_in.data[7:4]) == 4'he))
    else $error("incoming ais flag wrong");
  a_block_err: assert property (@(posedge clk) disable iff (!rst_n)
    tc_block_error |-> $past(rx_nr_beat))
    else $error("block error outside overhead beat");
  a_loss_lock: assert property (@(posedge clk) disable iff (!rst_n)
    align_reg == TCOH_LOST && rx_nr_beat && fas_ok
    |=> align_reg == TCOH_LOCKED ##1 !tc_loss_defect)
    else $error("lock not taken on good pattern");
endmodule

// ### dv/tcoh_far_end.sv
`timescale 1ns/1ps
module tcoh_far_end (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire tcoh_pkg::tcoh_beat_t line_in,
  input  wire logic                 line_in_valid,
  input  wire logic [7:0]           nr_mask,
  input  wire logic [7:0]           pay_mask,
  output      tcoh_pkg::tcoh_beat_t line_out,
  output      logic                 line_out_valid
);
  import tcoh_pkg::*;
  logic [7:0] hit;
  // line errors hit overhead or payload, never the frame markers
  assign hit = line_in.nr ? nr_mask :
               (line_in.fs | line_in.em) ? 8'h00 : pay_mask;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out       <= '0;
      line_out_valid <= 1'b0;
    end else begin
      line_out_valid <= line_in_valid;
      if (line_in_valid) begin
        line_out <= '{fs: line_in.fs, em: line_in.em, nr: line_in.nr,
                      data: line_in.data ^ hit};
      end else begin
        // idle bytes toggle so a stale copy never passes for data
        line_out.data <= ~line_out.data;
      end
    end
  end
endmodule

// ### dv/tcoh_top_tb.sv
`timescale 1ns/1ps
module tcoh_top_tb;
  import tcoh_pkg::*;
  logic        clk = 0, rst_n = 0, src_in_valid = 0;
  tcoh_beat_t  src_in = '0, src_out, snk_in, snk_out, b;
  logic        src_out_valid, snk_in_valid, snk_out_valid;
  logic        remote_defect_request = 0, remote_error_count_in = 0;
  logic        outgoing_error_indication = 0, outgoing_defect_request = 0;
  logic        incoming_signal_fail = 0, outgoing_block_error;
  logic        tc_block_error, far_block_error, outgoing_far_block_error;
  logic        remote_defect, outgoing_defect, incoming_ais, tc_loss_defect;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [7:0]  nr_mask = '0, pay_mask = '0, px, pbs, d8, sd, kd;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, tr[4], at[4], d;
  logic [3:0]  s_axi_wstrb = '0, vc = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  cb[2], pb[2], ei[2], eo[2], ni[2], no[2], pe[2], pn[2];
  logic [11:0] sh = '0;
  logic        sv = 0, kv = 0, sk = 0, kk = 0, rs = 0, os = 0;
  logic        xo = 0, xt = 0, xf = 0, xg = 0, xa = 0, xr = 0, xd = 0;
  tcoh_align_t lk = TCOH_LOST;
  int          fails = 0, num_checks = 0, cyc = 0;
  int          sf = 76, kf = 0, bad = 0, kc = 0;
  int          nf[2] = '{0, 0};

  tcoh_top dut (.*);
  tcoh_far_end far (.clk(clk), .rst_n(rst_n), .line_in(src_out),
    .line_in_valid(src_out_valid), .nr_mask(nr_mask),
    .pay_mask(pay_mask), .line_out(snk_in), .line_out_valid(snk_in_valid));

  always #50 clk = ~clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // shared lane model: parity, compensation, overhead replacement
  function automatic logic [7:0] lane(int l, tcoh_beat_t x,
                                      logic [7:0] nv);
    logic [7:0] o;
    o = x.data;
    if (x.fs) begin
      pb[l] = cb[l];
      cb[l] = 0;
      pe[l] = ei[l] ^ eo[l];
      pn[l] = ni[l] ^ no[l];
      nf[l]++;
    end
    cb[l] ^= x.data;
    if (x.em) begin
      o = pe[l] ^ pn[l] ^ x.data;
      ei[l] = x.data;
      eo[l] = o;
    end
    if (x.nr) begin
      o = nv;
      ni[l] = x.data;
      no[l] = nv;
    end
    return o;
  endfunction

  function automatic logic [1:0] mfb(int f);
    if (f < 8) return 2'b11;
    if (f == 8) return 2'b10;
    if (f <= 72) return tr[(f-9)/16][31-2*((f-9)%16) -: 2];
    if (f == 73) return {1'b0, remote_defect_request};
    if (f == 74) return {outgoing_defect_request, 1'b0};
    return 2'b00;
  endfunction

  function automatic logic [31:0] st();
    return {24'h0, vc, xa, xd, xr, lk == TCOH_LOST};
  endfunction

  task automatic wr(logic [7:0] a, logic [31:0] v, logic [3:0] s,
                    logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", r, s_axi_bresp);
  endtask

  task automatic rc(logic [7:0] a, logic [31:0] e, logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask

  always @(posedge clk) if (rst_n) begin
    chk("src_valid", sv, src_out_valid);
    if (sv && sk) chk("src_data", sd, src_out.data);
    sv = src_in_valid;
    if (src_in_valid) begin
      if (src_in.fs) sf = sf == 76 ? 1 : sf + 1;
      if (src_in.em) vc = 4'($countones(pb[0] ^ src_in.data));
      sd = lane(0, src_in, {incoming_signal_fail ? TCOH_IEC_AIS :
        vc == 0 ? TCOH_IEC_ZERO : vc, rs | remote_error_count_in,
        os | outgoing_error_indication, mfb(sf)});
      sk = nf[0] > 1 || !(src_in.em || src_in.nr);
    end
    if (src_in_valid && src_in.nr) begin
      rs = 0;
      os = 0;
    end else begin
      rs |= remote_error_count_in;
      os |= outgoing_error_indication;
    end
  end

  always @(posedge clk) if (rst_n) begin
    chk("snk_valid", kv, snk_out_valid);
    if (kv && kk) chk("snk_data", kd, snk_out.data);
    if (nf[1] > 1) chk("obe", xo, outgoing_block_error);
    if (nf[1] > 1) chk("tbe", xt, tc_block_error);
    chk("fbe", xf, far_block_error);
    chk("ofbe", xg, outgoing_far_block_error);
    chk("ais", xa, incoming_ais);
    chk("rdef", xr, remote_defect);
    chk("odef", xd, outgoing_defect);
    {xo, xt, xf, xg} = '0;
    kv = snk_in_valid;
    if (snk_in_valid) begin
      b = snk_in;
      if (b.fs) chk("loss", lk == TCOH_LOST, tc_loss_defect);
      kd = lane(1, b, 8'h00);
      kk = nf[1] > 1 || !(b.em || b.nr);
      if (b.em) kc = $countones(pb[1] ^ b.data);
      xo = b.em && kc != 0;
      if (b.nr) begin
        xt = kc != (b.data[7:4] > 8 ? 0 : b.data[7:4]);
        {xf, xg} = b.data[3:2];
        xa = b.data[7:4] == TCOH_IEC_AIS;
        sh = {sh[9:0], b.data[1:0]};
        if (lk == TCOH_LOCKED) begin
          kf = kf == 76 ? 1 : kf + 1;
          if (kf == 73) xr = b.data[0];
          if (kf == 74) xd = b.data[1];
          if (kf >= 9 && kf <= 72)
            at[(kf-9)/16][31-2*((kf-9)%16) -: 2] = b.data[1:0];
          if (kf == 8) begin
            bad = sh != TCOH_FAS_SEARCH ? bad + 1 : 0;
            if (bad == 2) lk = TCOH_LOST;
          end
        end else if (sh == TCOH_FAS_SEARCH) begin
          lk = TCOH_LOCKED;
          kf = 8;
          bad = 0;
        end
      end
    end
  end

  initial begin
    void'($urandom(87));
    // model history starts from the design's reset state, not unknown
    for (int l = 0; l < 2; l++)
      {cb[l], pb[l], ei[l], eo[l], ni[l], no[l], pe[l], pn[l]} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      tr[i] = $urandom;
      wr(TCOH_TXTI_OFS + 8'(4 * i), tr[i], 4'hf, TCOH_RESP_OKAY);
    end
    d = $urandom;
    wr(8'h1c, d, 4'h5, TCOH_RESP_OKAY);
    tr[3] = {tr[3][31:24], d[23:16], tr[3][15:8], d[7:0]};
    wr(8'h40, d, 4'hf, TCOH_RESP_SLVERR);
    rc(8'h40, 32'h0, TCOH_RESP_SLVERR);
    rc(8'h1c, tr[3], TCOH_RESP_OKAY);
    rc(TCOH_STATUS_OFS, st(), TCOH_RESP_OKAY);
    $display("test registers done");
    px = 0;
    // two bad alignment multiframes in the middle force loss and relock
    for (int m = 0; m < 6; m++) begin
      for (int f = 1; f <= 76; f++) begin
        nr_mask <= (m == 2 || m == 3) && f <= 8 ? 8'h01 :
                   ($urandom % 4 == 0 ? 8'($urandom) & 8'hfc : 8'h00);
        pay_mask <= $urandom % 4 == 0 ? 8'($urandom) : 8'h00;
        remote_error_count_in <= 1'($urandom);
        outgoing_error_indication <= 1'($urandom);
        incoming_signal_fail <= $urandom % 8 == 0;
        if (f == 1) remote_defect_request <= 1'($urandom);
        if (f == 1) outgoing_defect_request <= 1'($urandom);
        pbs = px;
        px = 0;
        for (int k = 0; k < 8; k++) begin
          d8 = k != 1 ? 8'($urandom) :
               pbs ^ ($urandom % 4 == 0 ? 8'hff >> ($urandom % 9) : 8'h00);
          px ^= d8;
          src_in <= '{fs: k == 0, em: k == 1, nr: k == 2, data: d8};
          src_in_valid <= 1;
          @(posedge clk);
          if ($urandom % 8 == 0) begin
            src_in_valid <= 0;
            @(posedge clk);
          end
        end
      end
    end
    src_in_valid <= 0;
    repeat (4) @(posedge clk);
    $display("test stream done");
    rc(TCOH_STATUS_OFS, st(), TCOH_RESP_OKAY);
    for (int i = 0; i < 4; i++)
      rc(TCOH_RXTI_OFS + 8'(4 * i), at[i], TCOH_RESP_OKAY);
    $display("test readback done");
    close_out();
  end
endmodule
